// file: core/rx_cfg_pkg.sv
// How it works
// (RQ1) Frame-start event with enable raises request
// (RQ2) Frame-start seen flag sticks until cleared
// (RQ3) Subcarrier event with enable raises request
// (RQ4) Subcarrier seen flag sticks, software clears
// (RQ5) Live subcarrier bit reads present state
// (RQ6) Partial byte written when allowed despite CRC
// (RQ7) Multi-frame mode keeps receiver running
// (RQ8) Multi-frame appends error register copy byte
// (RQ9) Type bit picks symbol or Type B end
// (RQ10) Type 0 with symbol bits 0 skips check
// (RQ11) Guard check flags overlong Type B gap as error
// (RQ12) Early error flushes FIFO, drops first bytes
// (RQ13) Suppressed frames raise no receive-done request
// (RQ14) Host waits three bytes before reading FIFO
// (RQ15) Baud codes 2 to 7 valid, others reserved
// (RQ16) Unit 0: window counts 16 carrier periods
// (RQ17) Unit 1: window counts half bit periods
// (RQ18) Inputs ignored for window after transmit ends
// (RQ19) Bit rate follows transmit data rate code
// (RQ20) Detection beats same-cycle software clear
package rx_cfg_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] RX_FRAME_DETECT_STATUS_OFS = 8'h34;  // Detect flags and enables
    localparam logic [7:0] RX_FRAMING_CONTROL_OFS     = 8'h35;  // Framing options and baud
    localparam logic [7:0] RX_IGNORE_WINDOW_OFS       = 8'h36;  // Unit bit and ignore count

    // Field positions of the detect status register
    localparam int SOF_IRQ_ENABLE_BIT       = 5;
    localparam int SOF_SEEN_FLAG_BIT        = 4;
    localparam int SUBCARRIER_IRQ_EN_BIT    = 2;
    localparam int SUBCARRIER_SEEN_BIT      = 1;
    localparam int SUBCARRIER_LIVE_BIT      = 0;

    // Field positions of the framing control register
    localparam int ALLOW_PARTIAL_BYTE_BIT   = 7;
    localparam int MULTI_FRAME_RECEIVE_BIT  = 6;
    localparam int END_FRAME_TYPE_BIT       = 5;
    localparam int GUARD_TIME_CHECK_BIT     = 4;
    localparam int DISTURBANCE_SUPPRESS_BIT = 3;
    localparam int BAUD_MSB                 = 2;

    // Field positions of the ignore window register
    localparam int RX_WAIT_UNIT_BIT         = 7;
    localparam int RX_IGNORE_COUNT_MSB      = 6;

    // Reset values
    localparam logic [7:0] RX_FRAMING_CONTROL_RST = 8'h00;
    localparam logic [7:0] RX_IGNORE_WINDOW_RST   = 8'h00;

    // Baud codes
    localparam logic [2:0] BAUD_SLOWEST_CODE = 3'h2;       // 26 kBd
    localparam logic [2:0] BAUD_FASTEST_CODE = 3'h7;       // 847 kBd

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CARRIER_PERIOD_PS   = 73746;            // 13.56 MHz carrier
    localparam int REF_CLK_PERIOD_PS   = 4000;             // 250 MHz system clock
    localparam int WAIT_UNIT_CARRIERS  = 16;               // Fixed window unit
    localparam int HALF_BIT_SLOW_CARR  = 256;              // Half bit at 26 kBd
    // Fixed unit in cycles, rounded up
    localparam int WAIT_UNIT_CYCLES =
        (WAIT_UNIT_CARRIERS * CARRIER_PERIOD_PS + REF_CLK_PERIOD_PS - 1) / REF_CLK_PERIOD_PS;
    // Slowest half bit in cycles, rounded up
    localparam int HALF_BIT_SLOW_CYCLES =
        (HALF_BIT_SLOW_CARR * CARRIER_PERIOD_PS + REF_CLK_PERIOD_PS - 1) / REF_CLK_PERIOD_PS;
    localparam int EGT_LIMIT_HALF_BITS  = 24;              // Byte-to-byte gap limit

    // Receive sequencer states
    typedef enum logic [3:0] {
        HALT_ST = 4'b0001,                                 // Receiver stopped
        WAIT_ST = 4'b0010,                                 // Ignore window running
        RECV_ST = 4'b0100,                                 // Listening
        ERRB_ST = 4'b1000                                  // Appending error byte
    } rx_state_type;

endpackage

// file: core/rf_receiver_frame_config.sv
`timescale 1ns/10ps
module rf_receiver_frame_config
    import rx_cfg_pkg::*;
#(
    parameter int unsigned HALF_BIT_SLOW = HALF_BIT_SLOW_CYCLES,  // Half bit at 26 kBd
    parameter int unsigned EGT_LIMIT     = EGT_LIMIT_HALF_BITS    // Gap limit, half bits
)(
    input  wire logic       REF_CLK,            // System clock
    input  wire logic       SRST,               // Synchronous reset
    input  wire logic [7:0] ADDR,               // Register address
    input  wire logic [7:0] WDATA,              // Write data
    input  wire logic       WR,                 // Write strobe
    input  wire logic       RD,                 // Read strobe
    output logic      [7:0] RDATA,              // Read data, cycle after RD
    input  wire logic       SOF_SEEN,           // Frame start detected pulse
    input  wire logic       SUBCARRIER_LIVE_FLAG,       // Subcarrier detected level
    input  wire logic       TX_END,             // Transmission finished pulse
    input  wire logic       RX_BYTE_VALID,      // Received byte pulse
    input  wire logic [7:0] RX_BYTE,            // Received byte
    input  wire logic [2:0] RX_BYTE_BITS,       // Valid bits of byte, 0 means all 8
    input  wire logic       RX_ERROR,           // Error or collision pulse
    input  wire logic       RX_FRAME_END,       // Frame end pulse
    input  wire logic       CRC_ENABLE,         // Receive CRC enabled
    input  wire logic [7:0] ERROR_REG,          // Error register contents
    input  wire logic [1:0] EOF_SYMBOL_BITS,    // Low bits of end symbol config
    input  wire logic [2:0] TX_DATA_BIT_FREQUENCY_CODE,     // Transmit data rate code
    output logic            RX_FRAME_START_IRQ, // Frame start request; one cycle on frame start, high while enabled subcarrier present
    output logic            RX_DONE_IRQ,        // Receive complete request pulse
    output logic            FIFO_WR,            // FIFO write pulse
    output logic      [7:0] FIFO_WDATA,         // FIFO write data
    output logic            FIFO_FLUSH,         // FIFO reset pulse
    output logic            RX_STOPPED,         // Receiver terminated pulse
    output logic            PROTOCOL_ERR,       // Guard time error pulse
    output logic            RX_IGNORE,          // Ignore window active
    output logic            EOF_CHECK_EN,       // End of frame checked
    output logic            EOF_TYPE_B,         // Type B end expected
    output logic      [2:0] RX_BAUD_CODE,       // Receive baud code
    output logic            RX_BAUD_VALID       // Baud code not reserved
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        rx_state_type state;                    // Receive sequencer
        logic         sof_en;                   // Frame start request enable
        logic         sof_flag;                 // Frame start seen, sticky
        logic         subcarrier_irq_enable;                  // Subcarrier request enable
        logic         subc_flag;                // Subcarrier seen, sticky
        logic [7:0]   ctrl;                     // Framing control register
        logic [7:0]   wait_cfg;                 // Ignore window register
        logic [7:0]   rdata;                    // Read data
        logic         start_irq;                // Frame start request
        logic         done_irq;                 // Receive complete request
        logic         fifo_wr;                  // FIFO write
        logic [7:0]   fifo_data;                // FIFO data
        logic         fifo_flush;               // FIFO reset
        logic         stopped;                  // Receiver terminated
        logic         prot_err;                 // Guard time error
        logic [1:0]   byte_cnt;                 // Bytes in frame, saturates at 3
        logic [6:0]   win_units;                // Window units left
        logic [12:0]  pre_cnt;                  // Cycles left in current unit
        logic [17:0]  gap_cnt;                  // Cycles since last byte
        logic         gap_run;                  // Gap measurement armed
    } state_type;

    state_type cur_ff;                          // Registered state
    state_type nxt_ff;                          // Next state

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------

    // Half bit period in cycles for a rate code, slowest for reserved codes
    function automatic logic [12:0] half_bit_cycles(input logic [2:0] code);
        logic [31:0] slow;
        slow = 32'(HALF_BIT_SLOW);
        if (code < BAUD_SLOWEST_CODE)
        begin
            half_bit_cycles = slow[12:0];
        end
        else
        begin
            half_bit_cycles = 13'(slow >> (code - BAUD_SLOWEST_CODE));
        end
    endfunction

    // Read value of a register
    function automatic logic [7:0] read_reg(input state_type s, input logic [7:0] a,
                                            input logic live);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            RX_FRAME_DETECT_STATUS_OFS:
            begin
                v[SOF_IRQ_ENABLE_BIT]    = s.sof_en;
                v[SOF_SEEN_FLAG_BIT]     = s.sof_flag;
                v[SUBCARRIER_IRQ_EN_BIT] = s.subcarrier_irq_enable;
                v[SUBCARRIER_SEEN_BIT]   = s.subc_flag;
                v[SUBCARRIER_LIVE_BIT]   = live;                       // [RQ5]
            end
            RX_FRAMING_CONTROL_OFS: v = s.ctrl;
            RX_IGNORE_WINDOW_OFS:   v = s.wait_cfg;
            default:                v = 8'h00;                         // Unmapped reads zero
        endcase
        read_reg = v;
    endfunction

    // ------------------------------------------------------------------
    // Decoded controls
    // ------------------------------------------------------------------
    logic        listening;                     // Receiver takes input
    logic [12:0] half_cyc;                      // Half bit of data rate
    logic [12:0] unit_cyc;                      // Window unit length
    logic [17:0] gap_limit;                     // Guard gap limit in cycles
    logic        disturbance_suppress_enable;                       // Disturbance suppression on
    logic        partial_ok;                    // Byte may enter FIFO

    // Decode of configuration and window timing
    always_comb
    begin
        listening = (cur_ff.state == RECV_ST);                          // [RQ18]
        half_cyc  = half_bit_cycles(TX_DATA_BIT_FREQUENCY_CODE);                    // [RQ19]
        // Window unit: fixed carrier count or half bit
        if (cur_ff.wait_cfg[RX_WAIT_UNIT_BIT])
        begin
            unit_cyc = half_cyc;                                        // [RQ17]
        end
        else
        begin
            unit_cyc = 13'(WAIT_UNIT_CYCLES);                           // [RQ16]
        end
        gap_limit  = 18'(32'(half_cyc) * EGT_LIMIT);
        disturbance_suppress_enable    = cur_ff.ctrl[DISTURBANCE_SUPPRESS_BIT];
        // Incomplete byte kept only without CRC or when allowed
        partial_ok = (RX_BYTE_BITS == 3'h0) || !CRC_ENABLE
                     || cur_ff.ctrl[ALLOW_PARTIAL_BYTE_BIT];            // [RQ6]
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        nxt_ff            = cur_ff;
        // Pulses default low
        nxt_ff.start_irq  = 1'b0;
        nxt_ff.done_irq   = 1'b0;
        nxt_ff.fifo_wr    = 1'b0;
        nxt_ff.fifo_flush = 1'b0;
        nxt_ff.stopped    = 1'b0;
        nxt_ff.prot_err   = 1'b0;

        // Register writes; a zero written to a seen flag clears it
        if (WR)
        begin
            unique case (ADDR)
                RX_FRAME_DETECT_STATUS_OFS:
                begin
                    nxt_ff.sof_en  = WDATA[SOF_IRQ_ENABLE_BIT];
                    nxt_ff.subcarrier_irq_enable = WDATA[SUBCARRIER_IRQ_EN_BIT];
                    if (!WDATA[SOF_SEEN_FLAG_BIT])
                    begin
                        nxt_ff.sof_flag = 1'b0;
                    end
                    if (!WDATA[SUBCARRIER_SEEN_BIT])
                    begin
                        nxt_ff.subc_flag = 1'b0;
                    end
                end
                RX_FRAMING_CONTROL_OFS: nxt_ff.ctrl     = WDATA;
                RX_IGNORE_WINDOW_OFS:   nxt_ff.wait_cfg = WDATA;
                default: ;                                              // Unmapped ignored
            endcase
        end

        // Detection sets flags after the clear, so it wins
        if (listening && SOF_SEEN)
        begin
            nxt_ff.sof_flag = 1'b1;                                     // [RQ2] [RQ20]
        end
        if (listening && SUBCARRIER_LIVE_FLAG)
        begin
            nxt_ff.subc_flag = 1'b1;                                    // [RQ4] [RQ20]
        end
        // One shared frame start request
        nxt_ff.start_irq = listening && ((SOF_SEEN && cur_ff.sof_en)    // [RQ1]
                                      || (SUBCARRIER_LIVE_FLAG && cur_ff.subcarrier_irq_enable)); // [RQ3]

        // Read data stands only in the cycle after the strobe
        nxt_ff.rdata = RD ? read_reg(cur_ff, ADDR, SUBCARRIER_LIVE_FLAG) : 8'h00;

        // Receive sequencer
        unique case (cur_ff.state)
            HALT_ST:
            begin
                // Waits for the next transmission to end
            end
            WAIT_ST:
            begin
                // Count down units of the ignore window
                if (cur_ff.pre_cnt != 13'h0)
                begin
                    nxt_ff.pre_cnt = cur_ff.pre_cnt - 13'h1;
                end
                else if (cur_ff.win_units <= 7'h1)
                begin
                    nxt_ff.state = RECV_ST;                             // [RQ18]
                end
                else
                begin
                    nxt_ff.win_units = cur_ff.win_units - 7'h1;
                    nxt_ff.pre_cnt   = unit_cyc - 13'h1;
                end
            end
            RECV_ST:
            begin
                // Gap timer between bytes
                if (cur_ff.gap_run && (cur_ff.gap_cnt != 18'h3ffff))
                begin
                    nxt_ff.gap_cnt = cur_ff.gap_cnt + 18'h1;
                end
                if (RX_BYTE_VALID)
                begin
                    // Overlong guard time in Type B
                    if (cur_ff.gap_run && cur_ff.ctrl[GUARD_TIME_CHECK_BIT]
                        && cur_ff.ctrl[END_FRAME_TYPE_BIT] && (cur_ff.gap_cnt > gap_limit))
                    begin
                        nxt_ff.prot_err = 1'b1;                         // [RQ11]
                    end
                    nxt_ff.gap_cnt = 18'h0;
                    nxt_ff.gap_run = 1'b1;
                    if (cur_ff.byte_cnt != 2'h3)
                    begin
                        nxt_ff.byte_cnt = cur_ff.byte_cnt + 2'h1;
                    end
                    if (partial_ok)
                    begin
                        nxt_ff.fifo_wr   = 1'b1;                        // [RQ6]
                        nxt_ff.fifo_data = RX_BYTE;
                    end
                end
                if (RX_ERROR && disturbance_suppress_enable && (cur_ff.byte_cnt != 2'h3))
                begin
                    // Early error: drop bytes as disturbance and restart
                    nxt_ff.fifo_wr    = 1'b0;
                    nxt_ff.fifo_flush = 1'b1;                           // [RQ12]
                    nxt_ff.byte_cnt   = 2'h0;
                    nxt_ff.gap_run    = 1'b0;
                end
                else if (RX_FRAME_END)
                begin
                    nxt_ff.gap_run  = 1'b0;
                    nxt_ff.byte_cnt = 2'h0;
                    if (disturbance_suppress_enable && (cur_ff.byte_cnt != 2'h3))
                    begin
                        // Short frame is disturbance: flush, no request
                        nxt_ff.fifo_flush = 1'b1;                       // [RQ13]
                    end
                    else if (cur_ff.ctrl[MULTI_FRAME_RECEIVE_BIT])
                    begin
                        nxt_ff.done_irq = 1'b1;
                        nxt_ff.state    = ERRB_ST;                      // [RQ7]
                    end
                    else
                    begin
                        nxt_ff.done_irq = 1'b1;
                        nxt_ff.stopped  = 1'b1;
                        nxt_ff.state    = HALT_ST;
                    end
                end
            end
            ERRB_ST:
            begin
                // Append error register copy, keep receiving
                nxt_ff.fifo_wr   = 1'b1;                                // [RQ8]
                nxt_ff.fifo_data = ERROR_REG;
                nxt_ff.state     = RECV_ST;                             // [RQ7]
            end
        endcase

        // End of transmission opens the ignore window from any state, or starts listening at once when the count is zero
        if (TX_END)
        begin
            nxt_ff.byte_cnt  = 2'h0;
            nxt_ff.gap_run   = 1'b0;
            nxt_ff.win_units = cur_ff.wait_cfg[RX_IGNORE_COUNT_MSB:0];
            nxt_ff.pre_cnt   = unit_cyc - 13'h1;
            if (cur_ff.wait_cfg[RX_IGNORE_COUNT_MSB:0] == 7'h0)
            begin
                nxt_ff.state = RECV_ST;
            end
            else
            begin
                nxt_ff.state = WAIT_ST;                                 // [RQ18]
            end
        end

        // Synchronous reset
        if (SRST)
        begin
            nxt_ff           = '0;
            nxt_ff.state     = HALT_ST;
            nxt_ff.ctrl      = RX_FRAMING_CONTROL_RST;
            nxt_ff.wait_cfg  = RX_IGNORE_WINDOW_RST;
        end
    end

    // State register
    always_ff @(posedge REF_CLK)
    begin
        cur_ff <= nxt_ff;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    always_comb
    begin
        RDATA              = cur_ff.rdata;
        RX_FRAME_START_IRQ = cur_ff.start_irq;
        RX_DONE_IRQ        = cur_ff.done_irq;
        FIFO_WR            = cur_ff.fifo_wr;
        FIFO_WDATA         = cur_ff.fifo_data;
        FIFO_FLUSH         = cur_ff.fifo_flush;
        RX_STOPPED         = cur_ff.stopped;
        PROTOCOL_ERR       = cur_ff.prot_err;
        RX_IGNORE          = (cur_ff.state == WAIT_ST);
        EOF_TYPE_B         = cur_ff.ctrl[END_FRAME_TYPE_BIT];           // [RQ9]
        // No check when symbol type and both symbol bits are zero
        EOF_CHECK_EN       = cur_ff.ctrl[END_FRAME_TYPE_BIT]
                             || (EOF_SYMBOL_BITS != 2'h0);              // [RQ10]
        RX_BAUD_CODE       = cur_ff.ctrl[BAUD_MSB:0];
        RX_BAUD_VALID      = (cur_ff.ctrl[BAUD_MSB:0] >= BAUD_SLOWEST_CODE)
                             && (cur_ff.ctrl[BAUD_MSB:0] <= BAUD_FASTEST_CODE); // [RQ15]
    end

endmodule

// file: bench/rx_cfg_props.sv
`timescale 1ns/10ps
module rx_cfg_props (
    input wire logic       REF_CLK,
    input wire logic       SRST,
    input wire logic       RD,
    input wire logic       SUBCARRIER_LIVE_FLAG,
    input wire logic       SOF_SEEN,
    input wire logic       TX_END,
    input wire logic       RX_FRAME_END,
    input wire logic       RX_FRAME_START_IRQ,
    input wire logic       RX_DONE_IRQ,
    input wire logic       FIFO_WR,
    input wire logic       FIFO_FLUSH,
    input wire logic       RX_STOPPED,
    input wire logic       RX_IGNORE,
    input wire logic       EOF_CHECK_EN,
    input wire logic       EOF_TYPE_B,
    input wire logic       RX_BAUD_VALID,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] RDATA,
    input wire logic [1:0] EOF_SYMBOL_BITS,
    input wire logic [2:0] RX_BAUD_CODE
);
    // ------------------------------------------------------------------
    // Port relations
    // ------------------------------------------------------------------
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SRST);
    property p_baud; RX_BAUD_VALID == (RX_BAUD_CODE >= 3'h2); endproperty
    a_baud: assert property (p_baud) else $error("baud valid flag wrong");
    property p_eof; EOF_CHECK_EN == (EOF_TYPE_B || EOF_SYMBOL_BITS != 2'h0); endproperty
    a_eof: assert property (p_eof) else $error("end check enable wrong");
    property p_idle; !$past(RD) |-> RDATA == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("read data not idle");
    property p_live; RD && ADDR == 8'h34 |=> RDATA[0] == $past(SUBCARRIER_LIVE_FLAG); endproperty
    a_live: assert property (p_live) else $error("live bit wrong");
    property p_start; RX_FRAME_START_IRQ |-> $past(SOF_SEEN || SUBCARRIER_LIVE_FLAG); endproperty
    a_start: assert property (p_start) else $error("start request without event");
    property p_ign; $rose(RX_IGNORE) |-> $past(TX_END); endproperty
    a_ign: assert property (p_ign) else $error("window without transmit end");
    property p_quiet; RX_IGNORE && $past(RX_IGNORE) |-> !RX_FRAME_START_IRQ && !RX_DONE_IRQ;
    endproperty
    a_quiet: assert property (p_quiet) else $error("event taken in window");
    property p_done; RX_DONE_IRQ |-> $past(RX_FRAME_END) && !FIFO_FLUSH; endproperty
    a_done: assert property (p_done) else $error("done request wrong");
    property p_flush; FIFO_FLUSH |-> !FIFO_WR; endproperty
    a_flush: assert property (p_flush) else $error("write beside flush");
    property p_multi; RX_DONE_IRQ && !RX_STOPPED |=> FIFO_WR; endproperty
    a_multi: assert property (p_multi) else $error("error byte missing");
    c_done: cover property (RX_DONE_IRQ);
    c_flush: cover property (FIFO_FLUSH);
    c_win: cover property ($fell(RX_IGNORE));
endmodule
bind rf_receiver_frame_config rx_cfg_props props (.*);

// file: bench/rf_card_model.sv
`timescale 1ns/10ps
module rf_card_model (
    input  wire logic clk,
    output logic      sof,
    output logic      subc,
    output logic      bv,
    output logic [7:0] bd,
    output logic [2:0] bb,
    output logic      err,
    output logic      fe
);
    // ------------------------------------------------------------------
    // Card events, one cycle each except the subcarrier level; byte lines scramble when idle
    // ------------------------------------------------------------------
    initial {sof, subc, bv, bd, bb, err, fe} = '0;
    task sof_p; @(posedge clk) sof <= 1'b1; @(posedge clk) sof <= 1'b0; endtask
    task err_p; @(posedge clk) err <= 1'b1; @(posedge clk) err <= 1'b0; endtask
    task fe_p; @(posedge clk) fe <= 1'b1; @(posedge clk) fe <= 1'b0; endtask
    task subc_l(input logic v); @(posedge clk) subc <= v; endtask
    task byt(input logic [7:0] d, input logic [2:0] b);
        @(posedge clk);
        bv <= 1'b1; bd <= d; bb <= b;
        @(posedge clk);
        bv <= 1'b0; bd <= ~d; bb <= ~b;
    endtask
endmodule

// file: bench/tb_rf_receiver_frame_config.sv
`timescale 1ns/10ps
module tb_rf_receiver_frame_config;
    import rx_cfg_pkg::*;
    logic REF_CLK = 0, SRST = 1, WR = 0, RD = 0, TX_END = 0, CRC_ENABLE = 0;
    logic [7:0] ADDR = 0, WDATA = 0, ERROR_REG = 0, RDATA, FIFO_WDATA, RX_BYTE;
    logic [1:0] EOF_SYMBOL_BITS = 0;
    logic [2:0] TX_DATA_BIT_FREQUENCY_CODE = 3'h2, RX_BAUD_CODE, RX_BYTE_BITS;
    logic SOF_SEEN, SUBCARRIER_LIVE_FLAG, RX_BYTE_VALID, RX_ERROR, RX_FRAME_END, RX_FRAME_START_IRQ;
    logic RX_DONE_IRQ, FIFO_WR, FIFO_FLUSH, RX_STOPPED, PROTOCOL_ERR, RX_IGNORE;
    logic EOF_CHECK_EN, EOF_TYPE_B, RX_BAUD_VALID;
    int bad_count = 0, cmp_count = 0, n_wr, n_fl, n_dn, n_pe, n_st, k;
    localparam logic [23:0] ROWS [6] = '{24'h35ffff, 24'h368585, 24'h34ff24,
                                         24'h30ff00, 24'h350000, 24'h360000};
    rf_receiver_frame_config #(.HALF_BIT_SLOW(64), .EGT_LIMIT(24)) dut (.*);
    rf_card_model card (.clk(REF_CLK), .sof(SOF_SEEN), .subc(SUBCARRIER_LIVE_FLAG),
        .bv(RX_BYTE_VALID), .bd(RX_BYTE), .bb(RX_BYTE_BITS), .err(RX_ERROR), .fe(RX_FRAME_END));
    initial forever #2 REF_CLK = ~REF_CLK;
    // Pulse counters, each pulse seen one edge after it rises
    always @(posedge REF_CLK)
    begin
        n_wr += FIFO_WR; n_fl += FIFO_FLUSH; n_dn += RX_DONE_IRQ;
        n_pe += PROTOCOL_ERR; n_st += RX_STOPPED;
    end
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task chk(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e)
        begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task cyc(input int n); repeat (n) @(posedge REF_CLK); endtask
    task clr; #1 {n_wr, n_fl, n_dn, n_pe, n_st} = '0; endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge REF_CLK); ADDR <= a; WDATA <= d; WR <= 1'b1;
        @(posedge REF_CLK); WR <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge REF_CLK); ADDR <= a; RD <= 1'b1;
        @(posedge REF_CLK); RD <= 1'b0;
        #1 chk(RDATA, e);
    endtask
    // Starts the ignore window and measures how long it stands
    task win(input logic [7:0] cfg, input int e);
        wr(8'h36, cfg);
        @(posedge REF_CLK) TX_END <= 1'b1;
        @(posedge REF_CLK) TX_END <= 1'b0;
        k = 0;
        #1;
        while (RX_IGNORE === 1'b1 && k < 5000) begin @(posedge REF_CLK); #1 k++; end
        chk(k == e || k == e + 1, 8'h01);
    endtask
    task wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin #200us; bad_count++; wrap_up; end
    // ------------------------------------------------------------------
    // Main sequence; the FIFO is never read here
    // ------------------------------------------------------------------
    initial
    begin
        cyc(16); SRST <= 1'b0;
        rd(8'h34, 8'h00); rd(8'h35, RX_FRAMING_CONTROL_RST); rd(8'h36, RX_IGNORE_WINDOW_RST);
        chk({RX_IGNORE, RX_DONE_IRQ, FIFO_WR, RX_FRAME_START_IRQ}, 8'h00);
        foreach (ROWS[i])
        begin
            wr(ROWS[i][23:16], ROWS[i][15:8]); rd(ROWS[i][23:16], ROWS[i][7:0]);
        end
        for (k = 0; k < 8; k++)
        begin
            wr(8'h35, k); #1 chk({RX_BAUD_VALID, RX_BAUD_CODE}, {k >= 2, k[2:0]});
        end
        for (k = 0; k < 8; k++)
        begin
            wr(8'h35, k[2] << 5); EOF_SYMBOL_BITS <= k[1:0]; cyc(1);
            #1 chk({EOF_CHECK_EN, EOF_TYPE_B}, {k[2] | (k[1:0] != 0), k[2]});
        end
        win(8'h02, 2 * WAIT_UNIT_CYCLES);
        TX_DATA_BIT_FREQUENCY_CODE <= 3'h7;
        win(8'h82, 2 * (64 >> 5));
        wr(8'h34, 8'h24); card.sof_p(); #1 chk(RX_FRAME_START_IRQ, 1);
        rd(8'h34, 8'h34);
        fork card.sof_p(); wr(8'h34, 8'h24); join
        rd(8'h34, 8'h34);
        wr(8'h34, 8'h24); rd(8'h34, 8'h24);
        wr(8'h34, 8'h04); card.subc_l(1); cyc(2); #1 chk(RX_FRAME_START_IRQ, 1);
        rd(8'h34, 8'h07); card.subc_l(0); cyc(2); rd(8'h34, 8'h06);
        wr(8'h34, 8'h00); rd(8'h34, 8'h00);
        CRC_ENABLE <= 1'b1; wr(8'h35, 8'h00); clr;
        card.byt(8'ha5, 3'h3); cyc(2); chk(n_wr, 0);
        wr(8'h35, 8'h80); card.byt(8'h3c, 3'h3); cyc(2); chk(n_wr, 1);
        chk(FIFO_WDATA, 8'h3c);
        card.fe_p(); cyc(2); chk(n_dn * 16 + n_st, 8'h11);
        win(8'h00, 0); wr(8'h35, 8'h40); ERROR_REG <= 8'h5a; clr;
        card.byt(8'h11, 3'h0); card.fe_p(); cyc(3); chk(n_wr, 2); chk(FIFO_WDATA, 8'h5a);
        card.byt(8'h22, 3'h0); cyc(2); chk(n_wr * 16 + n_st, 8'h30);
        wr(8'h35, 8'h30); clr; card.byt(8'h01, 3'h0); cyc(10);
        card.byt(8'h02, 3'h0); cyc(3); chk(n_pe, 0);
        cyc(60); card.byt(8'h03, 3'h0); cyc(3); chk(n_pe, 1);
        win(8'h00, 0);
        wr(8'h35, 8'h08); clr; card.byt(8'h01, 3'h0); card.err_p(); cyc(2); chk(n_fl, 1);
        card.byt(8'h02, 3'h0); card.fe_p(); cyc(2); chk(n_fl * 16 + n_dn, 8'h20);
        repeat (3) card.byt(8'h04, 3'h0);
        card.fe_p(); cyc(2); chk(n_dn, 1);
        SRST <= 1'b1; cyc(2); SRST <= 1'b0; rd(8'h35, 8'h00); rd(8'h34, 8'h00);
        wrap_up;
    end
endmodule
